// [uivl_top.sv]
// Interrupt flags, vector and clock request of an asynchronous serial port.
// Assumes receive and transmit events come as one-cycle pulses on clk_sys_i.
//
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/10ps

// Summary of operation
// - Request the baud source clock when needed, overriding its control bits.
// - Hold the clock request until the port is idle, then release control.
// - One interrupt line shared by all transmit and receive events.
// - Set tx_ready_flag whenever the transmit buffer can take a character.
// - Transmit request only when tx flag, its enable and global enable set.
// - Writing the transmit buffer clears tx_ready_flag.
// - Power-up clear or soft reset sets tx flag, clears tx enable.
// - Receive flag set on each character loaded, subject to qualifiers.
// - Receive request only when rx flag, its enable and global enable set.
// - Power-up clear or soft reset clears rx flag and rx enable.
// - Reading the receive buffer clears the receive flag.
// - With error enable low, erroneous characters do not set rx flag; the code still lets an erroneous break set it when break enable is high.
// - Dormant: only address characters and enabled breaks set rx flag; plain mode only enabled breaks.
// - Break enable high: break sets break_detected and rx flag.
// - Start byte received sets start_byte_flag.
// - Transmit complete set once stop bit out and buffer empty.
// - Vector shows highest enabled pending flag; disabled flags ignored.
// - Reading the vector clears the flag it reports.
// - Any write to the vector clears all pending flags.
// - Further pending enabled flags raise the request again at once.
// - Codes: 0x00 none, 0x02 rx, 0x04 tx, 0x06 start, 0x08 complete.
module uivl_top (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic global_irq_enable_i,
  input wire logic baud_clock_off_i,
  input wire logic port_busy_i,
  input wire logic tx_buffer_empty_i,
  input wire logic rx_load_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_error_i,
  input wire logic rx_address_i,
  input wire logic rx_break_i,
  input wire logic start_byte_i,
  input wire logic tx_shift_done_i,
  output logic [7:0] tx_data_o,
  output logic tx_load_o,
  output logic irq_o,
  output logic baud_clock_req_o,
  output logic soft_reset_hold_o
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_r;
  logic rst_n_r;
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ****************************************
  // Bus decode
  // ****************************************
  // One wait cycle per access so read data is registered
  logic ack_r;
  logic acc;
  logic wr_hit;
  logic rd_hit;
  assign acc = (avs_read_i | avs_write_i) & !ack_r;
  assign wr_hit = avs_write_i & !ack_r;
  assign rd_hit = avs_read_i & !ack_r;

  logic [15:0] ctrl_r;
  logic [3:0] ifg_r;
  logic [3:0] ie_r;
  logic brk_r;
  logic [7:0] rxbuf_r;
  logic [15:0] iv_code;
  logic [3:0] iv_clr;
  logic swrst;
  assign swrst = ctrl_r[uivl_pkg::CTRL_SWRST];

  // ****************************************
  // Vector priority
  // ****************************************
  logic [3:0] pend;
  assign pend = ifg_r & ie_r;
  always_comb
  begin
    iv_code = uivl_pkg::IV_NONE;
    iv_clr = 4'h0;
    if (pend[uivl_pkg::FLG_RX])
    begin
      iv_code = uivl_pkg::IV_RX;
      iv_clr[uivl_pkg::FLG_RX] = 1'b1;
    end
    else if (pend[uivl_pkg::FLG_TX])
    begin
      iv_code = uivl_pkg::IV_TX;
      iv_clr[uivl_pkg::FLG_TX] = 1'b1;
    end
    else if (pend[uivl_pkg::FLG_STT])
    begin
      iv_code = uivl_pkg::IV_STT;
      iv_clr[uivl_pkg::FLG_STT] = 1'b1;
    end
    else if (pend[uivl_pkg::FLG_TXCPT])
    begin
      iv_code = uivl_pkg::IV_TXCPT;
      iv_clr[uivl_pkg::FLG_TXCPT] = 1'b1;
    end
  end

  logic iv_rd;
  logic iv_wr;
  assign iv_rd = rd_hit && avs_address_i == uivl_pkg::ADDR_IV;
  assign iv_wr = wr_hit && avs_address_i == uivl_pkg::ADDR_IV;

  // ****************************************
  // Receive qualification
  // ****************************************
  logic dorm_block;
  logic rx_set;
  logic brk_set;
  // Dormant in plain mode blocks all but enabled breaks; in multiprocessor modes only addresses and enabled breaks pass
  assign dorm_block = ctrl_r[uivl_pkg::CTRL_DORM] &
    ((ctrl_r[uivl_pkg::CTRL_MODE_LO +: 2] == uivl_pkg::MODE_UART) | !rx_address_i);
  assign brk_set = rx_load_i & rx_break_i & ctrl_r[uivl_pkg::CTRL_BRK_IE];
  assign rx_set = rx_load_i & !swrst & (brk_set | (!rx_break_i & !dorm_block
    & (!rx_error_i | ctrl_r[uivl_pkg::CTRL_ERR_IE])));

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      ctrl_r <= uivl_pkg::CTRL_RESET;
    else if (wr_hit && avs_address_i == uivl_pkg::ADDR_CTRL)
      ctrl_r <= avs_writedata_i[15:0];
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      ie_r <= 4'h0;
    else if (swrst)
    begin
      ie_r[uivl_pkg::FLG_RX] <= 1'b0;
      ie_r[uivl_pkg::FLG_TX] <= 1'b0;
    end
    else if (wr_hit && avs_address_i == uivl_pkg::ADDR_IE)
      ie_r <= avs_writedata_i[3:0];
  end

  // Hardware set wins over any bus clear in the same cycle, except a transmit buffer write keeps the tx flag clear
  logic [3:0] set_v;
  assign set_v = {tx_shift_done_i & tx_buffer_empty_i,
                  start_byte_i,
                  1'b0, rx_set};
  logic tx_wr;
  assign tx_wr = wr_hit && avs_address_i == uivl_pkg::ADDR_TXBUF;
  always_ff @(posedge clk_sys_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      ifg_r <= uivl_pkg::IFG_RESET;
    else if (swrst)
      ifg_r <= uivl_pkg::IFG_RESET;
    else
    begin
      ifg_r <= (ifg_r
        & ~(iv_wr ? 4'hF : 4'h0)
        & ~(iv_rd ? iv_clr : 4'h0)
        & ~((rd_hit && avs_address_i == uivl_pkg::ADDR_RXBUF) ? 4'h1 : 4'h0)
        & ~(tx_wr ? 4'h2 : 4'h0)
        & ~((wr_hit && avs_address_i == uivl_pkg::ADDR_IFG) ? ~avs_writedata_i[3:0] : 4'h0))
        | set_v;
      if (tx_buffer_empty_i && !tx_wr && !tx_load_o)
        ifg_r[uivl_pkg::FLG_TX] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      brk_r <= 1'b0;
    else if (swrst)
      brk_r <= 1'b0;
    else if (brk_set)
      brk_r <= 1'b1;
    else if (rd_hit && avs_address_i == uivl_pkg::ADDR_RXBUF)
      brk_r <= 1'b0;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      rxbuf_r <= 8'h00;
    else if (rx_load_i)
      rxbuf_r <= rx_data_i;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      tx_data_o <= 8'h00;
      tx_load_o <= 1'b0;
    end
    else
    begin
      tx_load_o <= tx_wr & !swrst;
      if (tx_wr)
        tx_data_o <= avs_writedata_i[7:0];
    end
  end

  // ****************************************
  // Bus answer
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      ack_r <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= acc;
      avs_waitrequest_o <= !acc;
      if (rd_hit)
      begin
        case (avs_address_i)
          uivl_pkg::ADDR_CTRL: avs_readdata_o <= {16'h0000, ctrl_r};
          uivl_pkg::ADDR_STATUS: avs_readdata_o <= {28'h0000000, brk_r, 3'h0} | {31'h0, port_busy_i};
          uivl_pkg::ADDR_RXBUF: avs_readdata_o <= {24'h000000, rxbuf_r};
          uivl_pkg::ADDR_TXBUF: avs_readdata_o <= {24'h000000, tx_data_o};
          uivl_pkg::ADDR_IE: avs_readdata_o <= {28'h0000000, ie_r};
          uivl_pkg::ADDR_IFG: avs_readdata_o <= {28'h0000000, ifg_r};
          uivl_pkg::ADDR_IV: avs_readdata_o <= {16'h0000, iv_code};
          default: avs_readdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************
  // Interrupt and clock request
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      irq_o <= 1'b0;
      baud_clock_req_o <= 1'b0;
      soft_reset_hold_o <= 1'b1;
    end
    else
    begin
      // Single shared line held high while global enable is set and any enabled flag stays pending
      irq_o <= global_irq_enable_i & (|pend);
      baud_clock_req_o <= baud_clock_off_i & (port_busy_i | !tx_buffer_empty_i);
      soft_reset_hold_o <= swrst;
    end
  end

endmodule // uivl_top

// [uivl_pkg.sv]
// Package for the serial port interrupt vector logic.
// Assumes an Avalon-MM slave with 32-bit data, one word per register.
package uivl_pkg;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_STATUS = 6'h0A;
  localparam logic [5:0] ADDR_RXBUF = 6'h0C;
  localparam logic [5:0] ADDR_TXBUF = 6'h0E;
  localparam logic [5:0] ADDR_IE = 6'h1A;
  localparam logic [5:0] ADDR_IFG = 6'h1C;
  localparam logic [5:0] ADDR_IV = 6'h1E;

  // ****************************************
  // Control word fields
  // ****************************************
  localparam int CTRL_MODE_LO = 9;
  localparam int CTRL_SYNC = 8;
  localparam int CTRL_ERR_IE = 5;
  localparam int CTRL_BRK_IE = 4;
  localparam int CTRL_DORM = 3;
  localparam int CTRL_SWRST = 0;
  localparam logic [15:0] CTRL_RESET = 16'h0001;

  // ****************************************
  // Flag and enable positions
  // ****************************************
  localparam int FLG_RX = 0;
  localparam int FLG_TX = 1;
  localparam int FLG_STT = 2;
  localparam int FLG_TXCPT = 3;
  localparam logic [3:0] IFG_RESET = 4'h2;
  localparam int STAT_BRK = 3;

  // ****************************************
  // Vector codes
  // ****************************************
  localparam logic [15:0] IV_NONE = 16'h0000;
  localparam logic [15:0] IV_RX = 16'h0002;
  localparam logic [15:0] IV_TX = 16'h0004;
  localparam logic [15:0] IV_STT = 16'h0006;
  localparam logic [15:0] IV_TXCPT = 16'h0008;

  localparam logic [1:0] MODE_UART = 2'h0;

endpackage

// [uivl_properties.sv]
// Port checks for the serial port interrupt vector block.
// Assumes binding to uivl_top and a registered bus answer one cycle after taking.
`timescale 1ns/10ps
module uivl_properties (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic global_irq_enable_i,
  input wire logic baud_clock_off_i,
  input wire logic port_busy_i,
  input wire logic tx_buffer_empty_i,
  input wire logic tx_load_o,
  input wire logic irq_o,
  input wire logic baud_clock_req_o,
  input wire logic soft_reset_hold_o
);
  // ****
  // Checks
  // ****
  // Internal reset leaves two flops late, so the clock request is judged after that
  logic [1:0] age_r;
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      age_r <= 2'h0;
    else if (age_r != 2'h3)
      age_r <= age_r + 2'h1;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  a_irq_gie: assert property (irq_o |-> $past(global_irq_enable_i))
    else $error("irq without global enable");
  a_req_cause: assert property (age_r == 2'h3 |-> baud_clock_req_o ==
    $past(baud_clock_off_i && (port_busy_i || !tx_buffer_empty_i))) else $error("clock request wrong");
  a_load_pulse: assert property (tx_load_o |=> !tx_load_o) else $error("load not a pulse");
  a_load_cause: assert property (tx_load_o |->
    $past(avs_write_i && avs_address_i == uivl_pkg::ADDR_TXBUF)) else $error("load without write");
  a_wait_stand: assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("answer too long");
  a_answer_bound: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |-> ##[0:2] !avs_waitrequest_o)
    else $error("no answer");
  a_soft_quiet: assert property (soft_reset_hold_o [*3] |=> !irq_o)
    else $error("irq in soft reset");
  a_vec_code: assert property (!avs_waitrequest_o &&
    $past(avs_read_i && avs_address_i == uivl_pkg::ADDR_IV)
    |-> avs_readdata_o inside {32'h0, 32'h2, 32'h4, 32'h6, 32'h8}) else $error("bad vector code");
  c_irq: cover property (irq_o);
  c_req: cover property (baud_clock_req_o);
  c_load: cover property (tx_load_o);
endmodule // uivl_properties
bind uivl_top uivl_properties uivl_properties_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .global_irq_enable_i(global_irq_enable_i),
  .baud_clock_off_i(baud_clock_off_i), .port_busy_i(port_busy_i), .tx_buffer_empty_i(tx_buffer_empty_i),
  .tx_load_o(tx_load_o), .irq_o(irq_o), .baud_clock_req_o(baud_clock_req_o), .soft_reset_hold_o(soft_reset_hold_o));

// [uivl_cpu_model.sv]
// Processor side: global enable and a count of taken interrupts.
// Assumes reset_n_i is held low at the start of the run.
`timescale 1ns/10ps
module uivl_cpu_model (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic irq_i,
  input wire logic gie_req_i,
  output logic global_irq_enable_o,
  output logic [7:0] irq_count_o
);
  logic irq_d_r;
  assign global_irq_enable_o = gie_req_i;
  // Counts rising edges only, so a level held high is one taken interrupt
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      irq_d_r <= 1'h0;
      irq_count_o <= 8'h00;
    end
    else
    begin
      irq_d_r <= irq_i;
      if (irq_i && !irq_d_r)
        irq_count_o <= irq_count_o + 8'h01;
    end
  end
endmodule // uivl_cpu_model

// [uivl_top_test.sv]
// Bus-driven tests of the interrupt vector block.
// Assumes the register map of uivl_pkg and a registered bus answer.
`timescale 1ns/10ps
module uivl_top_test;
  logic clk_sys_i, reset_n_i, avs_read_i, avs_write_i, gie_req, off, busy, empty;
  logic [5:0] avs_address_i, ev_r;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [7:0] tx_data_o, irq_count;
  logic avs_waitrequest_o, tx_load_o, irq_o, clk_req, swr, global_irq_enable;
  int n_mismatch, cmp_count;
  uivl_top uivl_top_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .global_irq_enable_i(global_irq_enable),
    .baud_clock_off_i(off), .port_busy_i(busy), .tx_buffer_empty_i(empty), .rx_load_i(ev_r[5]),
    .rx_data_i(8'h3C), .rx_error_i(ev_r[4]), .rx_address_i(ev_r[3]), .rx_break_i(ev_r[2]),
    .start_byte_i(ev_r[1]), .tx_shift_done_i(ev_r[0]), .tx_data_o(tx_data_o), .tx_load_o(tx_load_o),
    .irq_o(irq_o), .baud_clock_req_o(clk_req), .soft_reset_hold_o(swr));
  uivl_cpu_model uivl_cpu_model_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .irq_i(irq_o), .gie_req_i(gie_req),
    .global_irq_enable_o(global_irq_enable), .irq_count_o(irq_count));
  // ****
  // Tasks
  // ****
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask
  // Request held until the edge that samples waitrequest low
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge clk_sys_i);
    while (avs_waitrequest_o !== 1'h0)
      @(posedge clk_sys_i);
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    acc(1'h0, a, 32'h0);
    chk($sformatf("reg %h", a), exp, avs_readdata_o);
  endtask
  task automatic ev(input logic [5:0] v);
    @(posedge clk_sys_i);
    ev_r <= v;
    @(posedge clk_sys_i);
    ev_r <= 6'h00;
  endtask
  task automatic pins(input logic o, input logic b, input logic e);
    @(posedge clk_sys_i);
    off <= o;
    busy <= b;
    empty <= e;
    repeat (3) @(posedge clk_sys_i);
  endtask
  initial
  begin
    clk_sys_i = 1'h0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  initial
  begin
    repeat (5000) @(posedge clk_sys_i);
    n_mismatch++;
    close_out();
  end
  // ****
  // Tests
  // ****
  initial
  begin
    {reset_n_i, avs_read_i, avs_write_i, off, busy, empty} = 6'h00;
    {avs_address_i, ev_r, avs_writedata_i} = 44'h0;
    gie_req = 1'h1;
    repeat (3) @(posedge clk_sys_i);
    reset_n_i <= 1'h1;
    repeat (3) @(posedge clk_sys_i);
    rd(uivl_pkg::ADDR_CTRL, 32'h1);
    rd(uivl_pkg::ADDR_IFG, 32'h2);
    rd(uivl_pkg::ADDR_IV, 32'h0);
    acc(1'h1, uivl_pkg::ADDR_CTRL, 32'h0);
    acc(1'h1, uivl_pkg::ADDR_IE, 32'hF);
    chk("soft_reset_hold", 32'h0, {31'h0, swr});
    rd(uivl_pkg::ADDR_IV, 32'h4);
    ev(6'h01);
    rd(uivl_pkg::ADDR_IFG, 32'h0);
    ev(6'h20);
    ev(6'h02);
    rd(uivl_pkg::ADDR_IFG, 32'h5);
    chk("irq", 32'h1, {31'h0, irq_o});
    rd(uivl_pkg::ADDR_IV, 32'h2);
    // One more edge so the line reflects the flags left after the clear
    @(posedge clk_sys_i);
    chk("irq", 32'h1, {31'h0, irq_o});
    rd(uivl_pkg::ADDR_IV, 32'h6);
    rd(uivl_pkg::ADDR_IV, 32'h0);
    chk("irq", 32'h0, {31'h0, irq_o});
    ev(6'h20);
    gie_req <= 1'h0;
    repeat (2) @(posedge clk_sys_i);
    chk("irq", 32'h0, {31'h0, irq_o});
    gie_req <= 1'h1;
    rd(uivl_pkg::ADDR_RXBUF, 32'h3C);
    rd(uivl_pkg::ADDR_IFG, 32'h0);
    ev(6'h30);
    rd(uivl_pkg::ADDR_IFG, 32'h0);
    acc(1'h1, uivl_pkg::ADDR_CTRL, 32'h8);
    ev(6'h28);
    rd(uivl_pkg::ADDR_IFG, 32'h0);
    // Idle-line multiprocessor mode: only address characters pass
    acc(1'h1, uivl_pkg::ADDR_CTRL, 32'h208);
    ev(6'h20);
    rd(uivl_pkg::ADDR_IFG, 32'h0);
    ev(6'h28);
    rd(uivl_pkg::ADDR_IFG, 32'h1);
    rd(uivl_pkg::ADDR_RXBUF, 32'h3C);
    acc(1'h1, uivl_pkg::ADDR_CTRL, 32'h10);
    ev(6'h24);
    rd(uivl_pkg::ADDR_IFG, 32'h1);
    rd(uivl_pkg::ADDR_STATUS, 32'h8);
    ev(6'h02);
    acc(1'h1, uivl_pkg::ADDR_IV, 32'h0);
    rd(uivl_pkg::ADDR_IFG, 32'h0);
    pins(1'h0, 1'h0, 1'h1);
    rd(uivl_pkg::ADDR_IFG, 32'h2);
    ev(6'h01);
    rd(uivl_pkg::ADDR_IFG, 32'hA);
    pins(1'h0, 1'h0, 1'h0);
    acc(1'h1, uivl_pkg::ADDR_TXBUF, 32'h5A);
    rd(uivl_pkg::ADDR_IFG, 32'h8);
    chk("tx_data", 32'h5A, {24'h0, tx_data_o});
    pins(1'h1, 1'h1, 1'h0);
    chk("clk_req", 32'h1, {31'h0, clk_req});
    pins(1'h1, 1'h0, 1'h0);
    chk("clk_req", 32'h1, {31'h0, clk_req});
    pins(1'h1, 1'h0, 1'h1);
    chk("clk_req", 32'h0, {31'h0, clk_req});
    acc(1'h1, uivl_pkg::ADDR_CTRL, 32'h1);
    rd(uivl_pkg::ADDR_IFG, 32'h2);
    rd(uivl_pkg::ADDR_IE, 32'hC);
    chk("soft_reset_hold", 32'h1, {31'h0, swr});
    acc(1'h1, 6'h02, 32'hFFFF);
    rd(6'h02, 32'h0);
    // Six separate high stretches of the shared line were provoked above
    chk("irq_count", 32'h6, {24'h0, irq_count});
    close_out();
  end
endmodule // uivl_top_test
